/* File: hw/ulm_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ulm_map.svh"

module ulm_ctrl
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 line_error_event,
  input  wire logic                 rx_ready_level,
  input  wire logic                 rx_timeout_level,
  input  wire logic                 tx_empty_event,
  input  wire logic                 xoff_match_event,
  input  wire logic                 xon_match_event,
  input  wire logic                 tx_serial_data,
  input  wire logic                 rx_pin,
  input  wire logic                 cts_n,
  input  wire logic                 dsr_n,
  input  wire logic                 ri_n,
  input  wire logic                 cd_n,
  output logic                      tx_pin,
  output logic                      rx_serial_data,
  output logic                      dtr_n,
  output logic                      rts_n,
  output logic                      general_output_one_n,
  output logic                      general_output_two_n,
  output logic                      irq,
  output logic                      baud_base_tick,
  output logic      [3:0]           word_bits,
  output var ulm_pkg::ulm_stop_type stop_mode,
  output logic                      parity_enable,
  output logic                      parity_even,
  output logic                      parity_forced,
  output logic                      parity_forced_value,
  output logic                      tx_break,
  output logic                      loopback_mode,
  output logic                      fifo_enable,
  output logic      [15:0]          baud_divisor,
  output logic                      enhanced_enable
);
  import ulm_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  ulm_bus_type  bus_state;
  ulm_bus_type  next_bus_state;
  ulm_stop_type next_stop;
  logic [7:0]   interrupt_enable_mask;
  logic [7:0]   interrupt_identification;
  logic [7:0]   fifo_setup;
  logic [7:0]   line_format_control;
  logic [7:0]   modem_line_control;
  logic [7:0]   enhanced_feature_control;
  logic [7:0]   div_low;
  logic [7:0]   div_high;
  logic [3:0]   modem_delta;
  logic [3:0]   modem_prev;
  logic [4:0]   pin_s;
  logic [5:0]   held_code;
  logic [5:0]   code_sel;
  logic [5:0]   presc_cnt;
  logic [5:0]   presc_last;
  logic [7:0]   rd_byte;
  logic [7:0]   wbyte;
  logic         f_line;
  logic         f_rx;
  logic         f_to;
  logic         f_tx;
  logic         f_xoff;
  logic         f_cr;
  logic         rx_lvl_q;
  logic         to_lvl_q;
  logic         rts_prev;
  logic         cts_prev;

  // ****************************************
  // Pin synchronisation
  // ****************************************
  ulm_sync #(.W(5)) u_sync
  (
    .clk  (clk),
    .rst  (rst),
    .din  ({rx_pin, cd_n, ri_n, dsr_n, cts_n}),
    .dout (pin_s)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  wire       div_open    = line_format_control[`ULM_LF_DIV_ACCESS];
  wire       enh         = enhanced_feature_control[`ULM_EF_ENH];
  wire       loop        = modem_line_control[`ULM_MC_LOOP];
  wire       ir_mode     = modem_line_control[`ULM_MC_IR];
  wire       fifo_on     = fifo_setup[`ULM_FS_ENABLE];
  wire       hit_ie      = (paddr == `ULM_OFS_INT_ENABLE);
  wire       hit_id      = (paddr == `ULM_OFS_INT_IDENT);
  wire       hit_fs      = (paddr == `ULM_OFS_FIFO_SETUP);
  wire       hit_lf      = (paddr == `ULM_OFS_LINE_FORMAT);
  wire       hit_mc      = (paddr == `ULM_OFS_MODEM_CTRL);
  wire       hit_ms      = (paddr == `ULM_OFS_MODEM_STATUS);
  wire       hit_ef      = (paddr == `ULM_OFS_ENH_FEATURE);
  wire       hit_dl      = (paddr == `ULM_OFS_DIV_LOW);
  wire       hit_dh      = (paddr == `ULM_OFS_DIV_HIGH);
  wire       mapped      = hit_ie | hit_id | hit_fs | hit_lf | hit_mc | hit_ms
                         | hit_ef | hit_dl | hit_dh;
  wire       access      = psel & penable;
  wire       first_cycle = access & (bus_state == ULM_BUS_IDLE);
  wire       commit      = access & (bus_state == ULM_BUS_RESP) & mapped;
  wire       wr_commit   = commit & pwrite;
  wire       rd_commit   = commit & ~pwrite;
  wire       id_read     = rd_commit & hit_id;
  wire       ms_read     = rd_commit & hit_ms;
  assign     wbyte       = pwdata[7:0];

  // ****************************************
  // Modem status view
  // ****************************************
  // Loopback replaces pins by control bits
  wire       cts_st = loop ? modem_line_control[`ULM_MC_RTS]  : ~pin_s[0];
  wire       dsr_st = loop ? modem_line_control[`ULM_MC_DTR]  : ~pin_s[1];
  wire       ri_st  = loop ? modem_line_control[`ULM_MC_OUT1] : ~pin_s[2];
  wire       cd_st  = loop ? modem_line_control[`ULM_MC_OUT2] : ~pin_s[3];
  wire [3:0] ms_now = {cd_st, ri_st, dsr_st, cts_st};
  wire [3:0] ms_chg = {cd_st ^ modem_prev[3], modem_prev[2] & ~ri_st,
                       dsr_st ^ modem_prev[1], cts_st ^ modem_prev[0]};
  wire [7:0] ms_byte = {ms_now, modem_delta};

  // ****************************************
  // Interrupt sources
  // ****************************************
  wire rx_rise   = rx_ready_level & ~rx_lvl_q;
  wire to_rise   = rx_timeout_level & ~to_lvl_q;
  wire rts_rise  = rts_n & ~rts_prev;
  wire cts_rise  = cts_prev & ~cts_st;
  wire cr_set    = enh & ((rts_rise & interrupt_enable_mask[`ULM_IE_RTS])
                 | (cts_rise & interrupt_enable_mask[`ULM_IE_CTS]));
  wire p_line    = f_line & interrupt_enable_mask[`ULM_IE_LINE];
  wire p_rx      = f_rx & interrupt_enable_mask[`ULM_IE_RX];
  wire p_to      = f_to & interrupt_enable_mask[`ULM_IE_RX];
  wire p_tx      = f_tx & interrupt_enable_mask[`ULM_IE_TX_EMPTY];
  wire p_modem   = (|modem_delta) & interrupt_enable_mask[`ULM_IE_MODEM];
  wire p_xoff    = enh & f_xoff & interrupt_enable_mask[`ULM_IE_XOFF];
  wire p_cr      = enh & f_cr;
  wire any_pend  = p_line | p_rx | p_to | p_tx | p_modem | p_xoff | p_cr;

  // Highest level wins; timeout ranks just above data ready
  assign code_sel = p_line  ? `ULM_ID_LINE       :
                    p_to    ? `ULM_ID_RX_TIMEOUT :
                    p_rx    ? `ULM_ID_RX_DATA    :
                    p_tx    ? `ULM_ID_TX_EMPTY   :
                    p_modem ? `ULM_ID_MODEM      :
                    p_xoff  ? `ULM_ID_XOFF       :
                    p_cr    ? `ULM_ID_CTS_RTS    :
                    `ULM_ID_NONE;

  // An ident read clears only the returned source; XOFF is cleared by an XON match instead
  wire clr_line  = id_read & (held_code == `ULM_ID_LINE);
  wire clr_rx    = id_read & (held_code == `ULM_ID_RX_DATA);
  wire clr_to    = id_read & (held_code == `ULM_ID_RX_TIMEOUT);
  wire clr_tx    = id_read & (held_code == `ULM_ID_TX_EMPTY);
  wire clr_modem = ms_read | (id_read & (held_code == `ULM_ID_MODEM));
  wire clr_cr    = id_read & (held_code == `ULM_ID_CTS_RTS);

  // ****************************************
  // Read mux
  // ****************************************
  assign interrupt_identification = {fifo_on, fifo_on, code_sel};
  assign rd_byte = hit_ie ? interrupt_enable_mask    :
                   hit_id ? interrupt_identification :
                   hit_fs ? fifo_setup               :
                   hit_lf ? line_format_control      :
                   hit_mc ? modem_line_control       :
                   hit_ms ? ms_byte                  :
                   (hit_ef & div_open) ? enhanced_feature_control :
                   (hit_dl & div_open) ? div_low     :
                   (hit_dh & div_open) ? div_high    :
                   `ULM_RST_BYTE;

  // ****************************************
  // Bus response
  // ****************************************
  assign next_bus_state = first_cycle ? ULM_BUS_RESP : ULM_BUS_IDLE;

  // Read data and code frozen one cycle before commit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus_state <= ULM_BUS_IDLE;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h00000000;
      held_code <= `ULM_ID_NONE;
    end
    else
    begin
      bus_state <= next_bus_state;
      pready    <= first_cycle;
      pslverr   <= first_cycle & ~mapped;
      if (first_cycle)
      begin
        prdata    <= {24'h000000, rd_byte};
        held_code <= code_sel;
      end
    end
  end

  // ****************************************
  // Writable registers
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      interrupt_enable_mask    <= `ULM_RST_BYTE;
      line_format_control      <= `ULM_RST_BYTE;
      modem_line_control       <= `ULM_RST_BYTE;
      enhanced_feature_control <= `ULM_RST_BYTE;
      div_low                  <= `ULM_RST_BYTE;
      div_high                 <= `ULM_RST_BYTE;
    end
    else if (wr_commit)
    begin
      if (hit_ie)
      begin
        interrupt_enable_mask[`ULM_IE_MODEM:`ULM_IE_RX] <= wbyte[`ULM_IE_MODEM:`ULM_IE_RX];
        // Upper mask bits are latched only while enhanced mode is on
        if (enh)
        begin
          interrupt_enable_mask[`ULM_IE_ENH_HI:`ULM_IE_ENH_LO]
            <= wbyte[`ULM_IE_ENH_HI:`ULM_IE_ENH_LO];
        end
      end
      if (hit_lf)
      begin
        line_format_control <= wbyte;
      end
      if (hit_mc)
      begin
        modem_line_control <= wbyte;
      end
      if (hit_ef & div_open)
      begin
        enhanced_feature_control <= wbyte;
      end
      if (hit_dl & div_open)
      begin
        div_low <= wbyte;
      end
      if (hit_dh & div_open)
      begin
        div_high <= wbyte;
      end
    end
  end

  // Setup bits 7 to 3 only stick while the enable bit is written high
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fifo_setup <= `ULM_RST_BYTE;
    end
    else if (wr_commit & hit_fs)
    begin
      fifo_setup[`ULM_FS_ENABLE] <= wbyte[`ULM_FS_ENABLE];
      if (wbyte[`ULM_FS_ENABLE])
      begin
        fifo_setup[`ULM_FS_KEEP_HI:`ULM_FS_KEEP_LO] <= wbyte[`ULM_FS_KEEP_HI:`ULM_FS_KEEP_LO];
      end
    end
  end

  // ****************************************
  // Sticky source flags, set beats clear
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      f_line      <= 1'b0;
      f_rx        <= 1'b0;
      f_to        <= 1'b0;
      f_tx        <= 1'b0;
      f_xoff      <= 1'b0;
      f_cr        <= 1'b0;
      modem_delta <= 4'h0;
    end
    else
    begin
      f_line      <= line_error_event | (f_line & ~clr_line);
      f_rx        <= rx_rise | (f_rx & ~clr_rx);
      f_to        <= to_rise | (f_to & ~clr_to);
      f_tx        <= tx_empty_event | (f_tx & ~clr_tx);
      f_xoff      <= (enh & xoff_match_event) | (f_xoff & ~xon_match_event);
      f_cr        <= cr_set | (f_cr & ~clr_cr);
      modem_delta <= ms_chg | (modem_delta & {4{~clr_modem}});
    end
  end

  // Edge history for level and pin sources
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_lvl_q   <= 1'b0;
      to_lvl_q   <= 1'b0;
      rts_prev   <= 1'b1;
      cts_prev   <= 1'b0;
      modem_prev <= 4'h0;
    end
    else
    begin
      rx_lvl_q   <= rx_ready_level;
      to_lvl_q   <= rx_timeout_level;
      rts_prev   <= rts_n;
      cts_prev   <= cts_st;
      modem_prev <= ms_now;
    end
  end

  // ****************************************
  // Line format decode
  // ****************************************
  wire       five_bit  = (line_format_control[`ULM_LF_LEN_HI:`ULM_LF_LEN_LO] == `ULM_LEN_FIVE);
  wire [3:0] next_word = `ULM_WORD_MIN
                       + {2'h0, line_format_control[`ULM_LF_LEN_HI:`ULM_LF_LEN_LO]};
  assign next_stop = ~line_format_control[`ULM_LF_STOP] ? ULM_STOP_ONE  :
                     five_bit                          ? ULM_STOP_HALF :
                     ULM_STOP_TWO;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      word_bits           <= `ULM_WORD_MIN;
      stop_mode           <= ULM_STOP_ONE;
      parity_enable       <= 1'b0;
      parity_even         <= 1'b0;
      parity_forced       <= 1'b0;
      parity_forced_value <= 1'b0;
    end
    else
    begin
      word_bits           <= next_word;
      stop_mode           <= next_stop;
      parity_enable       <= line_format_control[`ULM_LF_PAR_EN];
      parity_even         <= line_format_control[`ULM_LF_EVEN];
      parity_forced       <= line_format_control[`ULM_LF_PAR_EN]
                           & line_format_control[`ULM_LF_STICK];
      parity_forced_value <= ~line_format_control[`ULM_LF_EVEN];
    end
  end

  // ****************************************
  // Serial and modem pins
  // ****************************************
  // Loopback keeps the line at mark; infrared inverts so idle is low
  wire line_bit = loop ? 1'b1 : tx_serial_data;
  wire next_tx  = line_format_control[`ULM_LF_BREAK] ? 1'b0 :
                  (ir_mode ? ~line_bit : line_bit);
  wire next_rx  = loop ? tx_serial_data : (ir_mode ? ~pin_s[4] : pin_s[4]);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_pin               <= 1'b1;
      rx_serial_data       <= 1'b1;
      dtr_n                <= 1'b1;
      rts_n                <= 1'b1;
      general_output_one_n <= 1'b1;
      general_output_two_n <= 1'b1;
    end
    else
    begin
      tx_pin               <= next_tx;
      rx_serial_data       <= next_rx;
      dtr_n                <= loop | ~modem_line_control[`ULM_MC_DTR];
      rts_n                <= loop | ~modem_line_control[`ULM_MC_RTS];
      general_output_one_n <= loop | ~modem_line_control[`ULM_MC_OUT1];
      general_output_two_n <= loop | ~modem_line_control[`ULM_MC_OUT2];
    end
  end

  // ****************************************
  // Status outputs and interrupt pin
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq             <= 1'b0;
      tx_break        <= 1'b0;
      loopback_mode   <= 1'b0;
      fifo_enable     <= 1'b0;
      baud_divisor    <= 16'h0000;
      enhanced_enable <= 1'b0;
    end
    else
    begin
      irq             <= any_pend;
      tx_break        <= line_format_control[`ULM_LF_BREAK];
      loopback_mode   <= loop;
      fifo_enable     <= fifo_on;
      baud_divisor    <= {div_high, div_low};
      enhanced_enable <= enh;
    end
  end

  // ****************************************
  // Baud prescaler
  // ****************************************
  // One tick per 16 clocks, or per 64 with the extra divide
  assign presc_last = modem_line_control[`ULM_MC_PRESCALE] ? `ULM_PRE_LAST_4X
                                                           : `ULM_PRE_LAST_1X;
  wire presc_wrap   = (presc_cnt >= presc_last);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      presc_cnt      <= `ULM_PRE_ZERO;
      baud_base_tick <= 1'b0;
    end
    else
    begin
      presc_cnt      <= presc_wrap ? `ULM_PRE_ZERO : presc_cnt + `ULM_PRE_ONE;
      baud_base_tick <= presc_wrap;
    end
  end
endmodule

`default_nettype wire

/* File: include/ulm_map.svh */
`ifndef ULM_MAP_SVH
`define ULM_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ULM_OFS_INT_ENABLE   8'h00
`define ULM_OFS_INT_IDENT    8'h04
`define ULM_OFS_FIFO_SETUP   8'h08
`define ULM_OFS_LINE_FORMAT  8'h0c
`define ULM_OFS_MODEM_CTRL   8'h10
`define ULM_OFS_MODEM_STATUS 8'h14
`define ULM_OFS_ENH_FEATURE  8'h18
`define ULM_OFS_DIV_LOW      8'h1c
`define ULM_OFS_DIV_HIGH     8'h20

// ****************************************
// Reset values
// ****************************************
`define ULM_RST_BYTE         8'h00

// ****************************************
// Interrupt enable mask bits
// ****************************************
`define ULM_IE_RX            0
`define ULM_IE_TX_EMPTY      1
`define ULM_IE_LINE          2
`define ULM_IE_MODEM         3
`define ULM_IE_XOFF          5
`define ULM_IE_RTS           6
`define ULM_IE_CTS           7
`define ULM_IE_ENH_LO        4
`define ULM_IE_ENH_HI        7

// ****************************************
// Identification codes, bits 5 to 0
// ****************************************
`define ULM_ID_NONE          6'h01
`define ULM_ID_LINE          6'h06
`define ULM_ID_RX_DATA       6'h04
`define ULM_ID_RX_TIMEOUT    6'h0c
`define ULM_ID_TX_EMPTY      6'h02
`define ULM_ID_MODEM         6'h00
`define ULM_ID_XOFF          6'h10
`define ULM_ID_CTS_RTS       6'h20

// ****************************************
// Line format control bits
// ****************************************
`define ULM_LF_LEN_LO        0
`define ULM_LF_LEN_HI        1
`define ULM_LF_STOP          2
`define ULM_LF_PAR_EN        3
`define ULM_LF_EVEN          4
`define ULM_LF_STICK         5
`define ULM_LF_BREAK         6
`define ULM_LF_DIV_ACCESS    7
`define ULM_WORD_MIN         4'h5
`define ULM_LEN_FIVE         2'h0

// ****************************************
// Modem line control bits
// ****************************************
`define ULM_MC_DTR           0
`define ULM_MC_RTS           1
`define ULM_MC_OUT1          2
`define ULM_MC_OUT2          3
`define ULM_MC_LOOP          4
`define ULM_MC_IR            6
`define ULM_MC_PRESCALE      7

// ****************************************
// Other fields and counts
// ****************************************
`define ULM_EF_ENH           4
`define ULM_FS_ENABLE        0
`define ULM_FS_KEEP_LO       3
`define ULM_FS_KEEP_HI       7
`define ULM_PRE_LAST_1X      6'h0f
`define ULM_PRE_LAST_4X      6'h3f
`define ULM_PRE_ZERO         6'h00
`define ULM_PRE_ONE          6'h01

`endif

/* File: include/ulm_pkg.sv */
package ulm_pkg;

  typedef enum logic [1:0]
  {
    ULM_STOP_ONE  = 2'h0,
    ULM_STOP_HALF = 2'h1,
    ULM_STOP_TWO  = 2'h3
  } ulm_stop_type;

  typedef enum logic
  {
    ULM_BUS_IDLE = 1'b0,
    ULM_BUS_RESP = 1'b1
  } ulm_bus_type;

endpackage

/* File: hw/ulm_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module ulm_sync
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;

  // ****************************************
  // Two stages; first stage read only here
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // Pins idle high; matching that avoids a false edge after reset
      meta <= '1;
      dout <= '1;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

`default_nettype wire

/* File: dv/ulm_modem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Modem side: pins follow the bench, rx echoes tx
// ****************************************
module ulm_modem_model
(
  input  wire logic       clk,
  input  wire logic       tx_pin,
  input  wire logic [3:0] want_n,
  output logic            cts_n,
  output logic            dsr_n,
  output logic            ri_n,
  output logic            cd_n,
  output logic            rx_pin
);
  // Cable delay of one clock keeps pin edges off the sampling edge
  always_ff @(posedge clk)
  begin
    {cd_n, ri_n, dsr_n, cts_n} <= want_n;
    rx_pin <= tx_pin;
  end
endmodule
`default_nettype wire

/* File: dv/ulm_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module ulm_ctrl_monitor
(
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic [7:0]           paddr,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 tx_pin,
  input wire logic                 dtr_n,
  input wire logic                 rts_n,
  input wire logic                 baud_base_tick,
  input wire logic [3:0]           word_bits,
  input wire ulm_pkg::ulm_stop_type stop_mode,
  input wire logic                 parity_enable,
  input wire logic                 parity_even,
  input wire logic                 parity_forced,
  input wire logic                 parity_forced_value,
  input wire logic                 tx_break,
  input wire logic                 loopback_mode,
  input wire logic                 fifo_enable
);
  import ulm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire id_rd = psel && penable && pready && !pwrite && paddr == 8'h04;
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_answer_one: assert property ($rose(penable) && psel |=> pready) else $error("late pready");
  a_id_fifo: assert property (id_rd |-> prdata[7:6] == {2{fifo_enable}})
    else $error("ident top bits wrong");
  a_id_code: assert property (id_rd |-> prdata[5:0] inside
    {6'h06, 6'h0c, 6'h04, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01}) else $error("bad ident code");
  a_word_len: assert property (word_bits >= 4'h5 && word_bits <= 4'h8)
    else $error("bad word length");
  a_stop_half: assert property (stop_mode != ULM_STOP_ONE |->
    (word_bits == 4'h5) == (stop_mode == ULM_STOP_HALF)) else $error("bad stop mode");
  a_force_par: assert property (parity_forced |->
    parity_enable && parity_forced_value != parity_even) else $error("bad forced parity");
  a_break_low: assert property (tx_break [*2] |-> !tx_pin) else $error("break not low");
  a_loop_quiet: assert property (loopback_mode [*2] |-> dtr_n && rts_n)
    else $error("modem outs active in loopback");
  a_tick_gap: assert property (baud_base_tick |=> !baud_base_tick [*8])
    else $error("tick too soon");
  c_line_read: cover property (id_rd && prdata[5:0] == 6'h06);
  c_break: cover property (tx_break [*2]);
  c_loop: cover property (loopback_mode [*2]);
endmodule
bind ulm_ctrl ulm_ctrl_monitor i_ulm_ctrl_monitor (.*);
`default_nettype wire

/* File: dv/uart_irq_line_modem_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_irq_line_modem_ctrl_tb;
  import ulm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tx_serial_data = 1'b1;
  logic line_error_event = 1'b0, rx_ready_level = 1'b0, rx_timeout_level = 1'b0, err;
  logic tx_empty_event = 1'b0, xoff_match_event = 1'b0, xon_match_event = 1'b0;
  logic pready, pslverr, rx_pin, cts_n, dsr_n, ri_n, cd_n, tx_pin, rx_serial_data, irq;
  logic dtr_n, rts_n, general_output_one_n, general_output_two_n, baud_base_tick, fifo_enable;
  logic parity_enable, parity_even, parity_forced, parity_forced_value, tx_break;
  logic loopback_mode, enhanced_enable;
  logic [7:0]  paddr = 8'h00, q, v;
  logic [7:0]  ids [6] = '{8'h06, 8'h0c, 8'h04, 8'h02, 8'h00, 8'h01};
  logic [3:0]  word_bits, want_n = 4'hf;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [15:0] baud_divisor;
  ulm_stop_type stop_mode;
  int fail_count = 0, tests_run = 0, n;
  ulm_ctrl i_ulm_ctrl (.*);
  ulm_modem_model i_ulm_modem_model (.*);
  always #10 clk = ~clk;
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string s, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("BAD %s exp %h got %h", s, exp, got);
      fail_count++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    bus(1'b0, a, 8'h00);
    chk("read", q, exp);
  endtask
  // Edge-to-edge spacing of the baud tick
  task automatic gap(output int c);
    c = 0;
    @(posedge clk iff baud_base_tick === 1'b1);
    do @(posedge clk); while (baud_base_tick !== 1'b1 && ++c < 100);
    c++;
  endtask
  function automatic logic [1:0] stop_of(input logic [7:0] f);
    return !f[2] ? 2'h0 : (f[1:0] == 2'h0 ? 2'h1 : 2'h3);
  endfunction
  task automatic give_verdict;
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(32'h3759));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(8'h04, 8'h01);
    bus(1'b1, 8'h00, 8'h0f);
    line_error_event <= 1'b1;
    tx_empty_event <= 1'b1;
    rx_ready_level <= 1'b1;
    rx_timeout_level <= 1'b1;
    want_n <= 4'he;
    @(posedge clk);
    line_error_event <= 1'b0;
    tx_empty_event <= 1'b0;
    repeat (8) @(posedge clk);
    chk("irq", irq, 1'b1);
    foreach (ids[i]) rd(8'h04, ids[i]);
    repeat (3) @(posedge clk);
    chk("irq", irq, 1'b0);
    repeat (12)
    begin
      v = 8'($urandom);
      bus(1'b1, 8'h0c, v);
      repeat (2) @(posedge clk);
      chk("len", word_bits, {2'h0, v[1:0]} + 4'h5);
      chk("stop", stop_mode, stop_of(v));
      chk("par", {parity_enable, parity_even, parity_forced, parity_forced_value},
          {v[3], v[4], v[3] & v[5], ~v[4]});
      chk("brk", {tx_break, tx_pin}, {v[6], ~v[6]});
      rd(8'h0c, v);
    end
    bus(1'b1, 8'h0c, 8'h00);
    bus(1'b1, 8'h1c, 8'h5a);
    rd(8'h1c, 8'h00);
    bus(1'b1, 8'h0c, 8'h80);
    bus(1'b1, 8'h1c, 8'h5a);
    bus(1'b1, 8'h18, 8'h10);
    rd(8'h1c, 8'h5a);
    bus(1'b1, 8'h0c, 8'h00);
    chk("div", {enhanced_enable, baud_divisor}, 17'h1005a);
    bus(1'b1, 8'h00, 8'h20);
    xoff_match_event <= 1'b1;
    @(posedge clk);
    xoff_match_event <= 1'b0;
    repeat (3) @(posedge clk);
    rd(8'h04, 8'h10);
    rd(8'h04, 8'h10);
    xon_match_event <= 1'b1;
    @(posedge clk);
    xon_match_event <= 1'b0;
    repeat (3) @(posedge clk);
    rd(8'h04, 8'h01);
    bus(1'b1, 8'h00, 8'h40);
    bus(1'b1, 8'h10, 8'h02);
    bus(1'b1, 8'h10, 8'h00);
    rd(8'h04, 8'h20);
    rd(8'h04, 8'h01);
    bus(1'b1, 8'h00, 8'h00);
    repeat (8)
    begin
      v = 8'($urandom) & 8'h8f;
      bus(1'b1, 8'h10, v);
      repeat (2) @(posedge clk);
      chk("modem", {general_output_two_n, general_output_one_n, rts_n, dtr_n}, 4'(~v[3:0]));
    end
    bus(1'b1, 8'h10, 8'h13);
    tx_serial_data <= 1'b0;
    repeat (2) @(posedge clk);
    chk("loop", {loopback_mode, rx_serial_data, dtr_n, tx_pin}, 4'hb);
    tx_serial_data <= 1'b1;
    bus(1'b0, 8'h14, 8'h00);
    chk("mstat", q[7:4], 4'h3);
    bus(1'b1, 8'h10, 8'h40);
    repeat (6) @(posedge clk);
    chk("ir", {tx_pin, rx_serial_data}, 2'h1);
    bus(1'b1, 8'h10, 8'h00);
    gap(n);
    gap(n);
    chk("tick", n, 16);
    bus(1'b1, 8'h10, 8'h80);
    gap(n);
    gap(n);
    chk("tick4", n, 64);
    bus(1'b1, 8'h40, 8'hff);
    chk("werr", err, 1'b1);
    rd(8'h40, 8'h00);
    chk("rerr", err, 1'b1);
    bus(1'b0, 8'h14, 8'h00);
    bus(1'b1, 8'h08, 8'h01);
    rd(8'h04, 8'hc1);
    give_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
